// >>> fpc_regs.svh
// Register map, field positions, reset values and response codes of the channel
// Function
// - Word one top nibble: identifier; bit eleven zero
// - Word one low eleven bits: base number
// - Page 0x00, 0x80, 0x90: 0, 2000, 6000
// - Page 0x20, 0xA0, 0x50: 8000, 10000, 20000
// - Word two high byte: subindex 0 to 254
// - 32-bit value: word three high, four low
// - 16-bit value in word four, three zero
// - One request and one response per telegram
// - Requests and responses never split across telegrams
// - Failure: response identifier 7, code in word four
// - Code 0 unknown number, 1 read-only
// - Code 2 out of limits, 3 bad subindex
// - Code 4 field request on plain parameter
// - Code 5 word or double word mismatch
// - Codes 6, 7, 12: reset-only, descriptive, keyword
// - Code 11 change without master control
// - Code 17 operating state, 107 controller enabled
// - Code 20 illegal discrete value, 104 illegal value
// - Code 101 deactivated, 102 channel too small
// - Code 106 for identifiers 5, 10, 15
// - Codes 200/201 narrowed limits, 204 no authorization
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// Register offsets, byte addresses
`define FPC_CTRL_ADDR    8'h00
`define FPC_STATUS_ADDR  8'h04
`define FPC_FORCE_ADDR   8'h08
`define FPC_ENT_BASE     4'h1
`define FPC_ENT_CFG      2'h0
`define FPC_ENT_VAL      2'h1
`define FPC_ENT_MIN      2'h2
`define FPC_ENT_MAX      2'h3

// Control register bits
`define FPC_CTRL_MASTER  0
`define FPC_CTRL_RUN     1
`define FPC_CTRL_BLOCK   2
`define FPC_CTRL_AUTH    3
`define FPC_CTRL_RESET   32'h0000_0009

// Entry configuration bits and the force register arm bit
`define FPC_CFG_RO       16
`define FPC_CFG_DW       17
`define FPC_CFG_IDX      18
`define FPC_CFG_OFF      19
`define FPC_CFG_CNT_LO   20
`define FPC_FORCE_ARM    8

// Page index encodings, base number limit and subindex limit
`define FPC_PAGE_0       8'h00
`define FPC_PAGE_2K      8'h80
`define FPC_PAGE_6K      8'h90
`define FPC_PAGE_8K      8'h20
`define FPC_PAGE_10K     8'hA0
`define FPC_PAGE_20K     8'h50
`define FPC_BASE_MAX     11'h7CF
`define FPC_SUB_MAX      8'hFE

// Response identifiers and error codes
`define FPC_RID_ERR      4'h7
`define FPC_E_NONUM      16'h0000
`define FPC_E_RO         16'h0001
`define FPC_E_LIMIT      16'h0002
`define FPC_E_SUB        16'h0003
`define FPC_E_NOFIELD    16'h0004
`define FPC_E_TYPE       16'h0005
`define FPC_E_MASTER     16'h000B
`define FPC_E_STATE      16'h0011
`define FPC_E_OFF        16'h0065
`define FPC_E_WIDTH      16'h0066
`define FPC_E_UNSUP      16'h006A
`define FPC_E_RUN        16'h006B
`define FPC_E_AUTH       16'h00CC

`endif

// >>> fpc_pkg.sv
// Types shared by the parameter channel modules
package fpc_pkg;
    typedef logic [15:0] fpc_word_t;
    typedef logic [3:0]  fpc_rid_t;
    // One entry of the parameter table
    typedef struct packed {
        logic [7:0]  cnt;
        logic        off;
        logic        idx;
        logic        dw;
        logic        ro;
        logic [15:0] num;
    } fpc_cfg_t;
endpackage : fpc_pkg

// >>> fpc_dec_if.sv
// Decoded request fields passed from the decoder to the channel core
`timescale 1ns/1ps
`default_nettype none
interface fpc_dec_if;
    import fpc_pkg::*;
    fpc_rid_t    rid;      // Request identifier
    logic [15:0] eff_num;  // Base plus page offset
    logic        num_ok;   // Page known and base in range
    logic        field;    // Field request
    logic        change;   // Change request
    logic        dw_req;   // Double word change
    logic        wd_req;   // Word change
    logic        unsup;    // Unsupported identifier
    logic [31:0] val;      // Value carried by the request
    modport dec (output rid, eff_num, num_ok, field, change, dw_req, wd_req, unsup, val);
    modport core (input rid, eff_num, num_ok, field, change, dw_req, wd_req, unsup, val);
endinterface : fpc_dec_if
`default_nettype wire

// >>> fpc_decode.sv
// Splits a request telegram into identifier, effective number and value
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_decode
    import fpc_pkg::*;
(
    // Request words
    input  wire fpc_word_t w1,
    input  wire fpc_word_t w2,
    input  wire fpc_word_t w3,
    input  wire fpc_word_t w4,
    // Decoded fields
    fpc_dec_if.dec         d
);
    logic [15:0] offset;  // Offset chosen by the page byte
    logic        page_ok; // Page byte is one of the known ranges

    // Page byte to number offset; unknown pages address nothing
    always_comb begin
        page_ok = 1'b1;
        case (w2[7:0])
            `FPC_PAGE_0:   offset = 16'h0000;
            `FPC_PAGE_2K:  offset = 16'h07D0;
            `FPC_PAGE_6K:  offset = 16'h1770;
            `FPC_PAGE_8K:  offset = 16'h1F40;
            `FPC_PAGE_10K: offset = 16'h2710;
            `FPC_PAGE_20K: offset = 16'h4E20;
            default: begin
                offset  = 16'h0000;
                page_ok = 1'b0;
            end
        endcase
    end

    // Identifier classes
    always_comb begin
        d.rid    = w1[15:12];
        d.field  = 1'b0;
        d.change = 1'b0;
        d.dw_req = 1'b0;
        d.wd_req = 1'b0;
        d.unsup  = 1'b0;
        case (w1[15:12])
            4'h2, 4'hE: d.wd_req = 1'b1;
            4'h3, 4'hD: d.dw_req = 1'b1;
            4'h6:       d.field  = 1'b1;
            4'h7, 4'hC: begin
                d.field  = 1'b1;
                d.wd_req = 1'b1;
            end
            4'h8, 4'hB: begin
                d.field  = 1'b1;
                d.dw_req = 1'b1;
            end
            4'h5, 4'hA, 4'hF: d.unsup = 1'b1;
            default: ;
        endcase
        d.change = d.wd_req | d.dw_req;
    end

    // Base number 1..1999 plus offset
    assign d.eff_num = {5'h00, w1[10:0]} + offset;
    assign d.num_ok  = page_ok && (w1[10:0] != 11'h000) && (w1[10:0] <= `FPC_BASE_MAX);
    // Word values live in word four only; the high word is dropped
    assign d.val     = d.dw_req ? {w3, w4} : {16'h0000, w4};
endmodule : fpc_decode
`default_nettype wire

// >>> fpc_pack.sv
// Registers a whole response telegram and its valid pulse
`timescale 1ns/1ps
`default_nettype none
module fpc_pack
    import fpc_pkg::*;
(
    // Clock and reset
    input  wire logic      clk_sys,
    input  wire logic      rst,
    // Response content
    input  wire logic      go,
    input  wire fpc_rid_t  rid,
    input  wire fpc_word_t num_w,
    input  wire fpc_word_t idx_w,
    input  wire logic [31:0] val,
    // Response telegram
    output logic           resp_valid,
    output fpc_word_t      resp_w1,
    output fpc_word_t      resp_w2,
    output fpc_word_t      resp_w3,
    output fpc_word_t      resp_w4
);
    // All four words load together so no telegram is ever split
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_w1    <= 16'h0000;
            resp_w2    <= 16'h0000;
            resp_w3    <= 16'h0000;
            resp_w4    <= 16'h0000;
        end else begin
            resp_valid <= go;
            if (go) begin
                resp_w1 <= {rid, 1'b0, num_w[10:0]};
                resp_w2 <= idx_w;
                resp_w3 <= val[31:16];
                resp_w4 <= val[15:0];
            end
        end
    end
endmodule : fpc_pack
`default_nettype wire

// >>> fpc_channel.sv
// Parameter channel: request check, small parameter table, response build
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_channel
    import fpc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Request telegram, one cycle pulse
    input  wire logic        req_valid,
    input  wire fpc_word_t   req_w1,
    input  wire fpc_word_t   req_w2,
    input  wire fpc_word_t   req_w3,
    input  wire fpc_word_t   req_w4,
    // Response telegram
    output logic             resp_valid,
    output fpc_word_t        resp_w1,
    output fpc_word_t        resp_w2,
    output fpc_word_t        resp_w3,
    output fpc_word_t        resp_w4,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);
    localparam int NE = 4; // Table entries

    fpc_dec_if dif ();

    logic [31:0] ctrl_reg;          // Mode bits
    logic [8:0]  force_reg;         // Armed forced code
    logic [7:0]  last_code_reg;     // Last error code
    logic        last_err_reg;      // Last response was an error
    logic [15:0] resp_cnt_reg;      // Responses sent
    fpc_cfg_t    cfg_reg [NE];      // Entry attributes
    logic [31:0] val_reg [NE];      // Entry values
    logic [31:0] min_reg [NE];      // Entry lower limits
    logic [31:0] max_reg [NE];      // Entry upper limits
    logic [NE-1:0] hit;             // Entry matches the number
    logic        found;             // Some entry matches
    logic [1:0]  sel;               // Matching entry
    fpc_cfg_t    cfg;               // Attributes of the match
    logic        err;               // Request fails
    logic [15:0] code;              // Error code
    fpc_rid_t    rrid;              // Response identifier
    logic [31:0] rval;              // Response value
    logic        wr_ok;             // Change is carried out
    logic        ent_wr;            // Software writes an entry
    logic [1:0]  ent_sel;           // Entry addressed by software
    logic        force_use;         // Forced code chosen for this request

    // Request decoder
    fpc_decode u_dec (
        .w1 (req_w1),
        .w2 (req_w2),
        .w3 (req_w3),
        .w4 (req_w4),
        .d  (dif.dec)
    );

    // Number match, one comparator per entry
    for (genvar i = 0; i < NE; i++) begin : g_hit
        assign hit[i] = (cfg_reg[i].num == dif.eff_num);
    end

    // Lowest matching entry wins
    always_comb begin
        found = 1'b0;
        sel   = 2'h0;
        for (int k = NE - 1; k >= 0; k--) begin
            if (hit[k]) begin
                found = 1'b1;
                sel   = 2'(k);
            end
        end
        cfg = cfg_reg[sel];
    end

    // Check chain; the first failing test names the code
    // Order matters: number and state problems are reported before the
    // change checks, so a read never answers with a type or limit code
    always_comb begin
        err       = 1'b1;
        code      = `FPC_E_NONUM;
        force_use = 1'b0;
        if (dif.rid == 4'h0) begin
            err = 1'b0;
        end else if (dif.unsup) begin
            code = `FPC_E_UNSUP;
        end else if (!dif.num_ok || !found) begin
            code = `FPC_E_NONUM;
        end else if (cfg.off) begin
            code = `FPC_E_OFF;
        end else if (ctrl_reg[`FPC_CTRL_BLOCK]) begin
            code = `FPC_E_STATE;
        end else if (dif.rid == 4'h4) begin
            // Descriptive data never fits in four words
            code = `FPC_E_WIDTH;
        end else if (dif.field && !cfg.idx && (req_w2[15:8] != 8'h00)) begin
            code = `FPC_E_NOFIELD;
        end else if (cfg.idx && ((req_w2[15:8] > `FPC_SUB_MAX)
                                 || (req_w2[15:8] >= cfg.cnt))) begin
            code = `FPC_E_SUB;
        end else if (!dif.change) begin
            err = 1'b0;
        end else if (!ctrl_reg[`FPC_CTRL_MASTER]) begin
            code = `FPC_E_MASTER;
        end else if (!ctrl_reg[`FPC_CTRL_AUTH]) begin
            code = `FPC_E_AUTH;
        end else if (ctrl_reg[`FPC_CTRL_RUN]) begin
            code = `FPC_E_RUN;
        end else if (cfg.ro) begin
            code = `FPC_E_RO;
        end else if (dif.dw_req != cfg.dw) begin
            code = `FPC_E_TYPE;
        end else if ((dif.val < min_reg[sel]) || (dif.val > max_reg[sel])) begin
            code = `FPC_E_LIMIT;
        end else if (force_reg[`FPC_FORCE_ARM]) begin
            // Codes 6, 7, 12, 20, 104, 200, 201 come from firmware checks
            code      = {8'h00, force_reg[7:0]};
            force_use = 1'b1;
        end else begin
            err = 1'b0;
        end
    end

    // A change lands only when every check passed; failed changes leave the table alone
    assign wr_ok = req_valid && !err && dif.change;

    // Response identifier and value
    // Positive answers to identifiers 1 and 6 take word or double word from the entry, 9 the element count; change answers echo the request value
    always_comb begin
        rrid = 4'h0;
        rval = 32'h0000_0000;
        if (err) begin
            rrid = `FPC_RID_ERR;
            rval = {16'h0000, code};
        end else begin
            case (dif.rid)
                4'h1, 4'h6: begin
                    if (dif.rid == 4'h6) begin
                        rrid = cfg.dw ? 4'h5 : 4'h4;
                    end else begin
                        rrid = cfg.dw ? 4'h2 : 4'h1;
                    end
                    // A word value leaves the high word at zero
                    rval = cfg.dw ? val_reg[sel] : {16'h0000, val_reg[sel][15:0]};
                end
                4'h2, 4'hE: begin
                    rrid = 4'h1;
                    rval = dif.val;
                end
                4'h3, 4'hD: begin
                    rrid = 4'h2;
                    rval = dif.val;
                end
                4'h7, 4'hC: begin
                    rrid = 4'h4;
                    rval = dif.val;
                end
                4'h8, 4'hB: begin
                    rrid = 4'h5;
                    rval = dif.val;
                end
                4'h9: begin
                    rrid = 4'h6;
                    rval = {24'h00_0000, cfg.cnt};
                end
                default: rrid = 4'h0;
            endcase
        end
    end

    // Response register stage
    // The pack stage gives every answer exactly one cycle of latency
    fpc_pack u_pack (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .go         (req_valid),
        .rid        (rrid),
        .num_w      (req_w1),
        .idx_w      (req_w2),
        .val        (rval),
        .resp_valid (resp_valid),
        .resp_w1    (resp_w1),
        .resp_w2    (resp_w2),
        .resp_w3    (resp_w3),
        .resp_w4    (resp_w4)
    );

    // Software entry window: four slots of sixteen bytes from the entry base
    assign ent_wr  = reg_wr && (reg_addr[7:4] >= `FPC_ENT_BASE)
                     && (reg_addr[7:4] < 4'(`FPC_ENT_BASE + NE));
    assign ent_sel = 2'(reg_addr[7:4] - `FPC_ENT_BASE);

    // Control register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= `FPC_CTRL_RESET;
        end else if (reg_wr && (reg_addr == `FPC_CTRL_ADDR)) begin
            ctrl_reg <= {28'h000_0000, reg_wdata[3:0]};
        end
    end

    // Forced code: one-shot, used by the next accepted change
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            force_reg <= 9'h000;
        end else if (reg_wr && (reg_addr == `FPC_FORCE_ADDR)) begin
            force_reg <= reg_wdata[8:0];
        end else if (req_valid && force_use) begin
            // Only the forced branch disarms; an earlier check that happens to
            // give the same number must not use up the armed code
            force_reg[`FPC_FORCE_ARM] <= 1'b0;
        end
    end

    // Status: last code and response count
    // The count wraps silently after 65535 responses
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            last_code_reg <= 8'h00;
            last_err_reg  <= 1'b0;
            resp_cnt_reg  <= 16'h0000;
        end else if (req_valid) begin
            last_code_reg <= err ? code[7:0] : 8'h00;
            last_err_reg  <= err;
            resp_cnt_reg  <= resp_cnt_reg + 16'h0001;
        end
    end

    // Table storage; a telegram write beats a software write
    // Indexed entries keep one value shared by all elements
    for (genvar i = 0; i < NE; i++) begin : g_ent
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                cfg_reg[i] <= '0;
                val_reg[i] <= 32'h0000_0000;
                min_reg[i] <= 32'h0000_0000;
                max_reg[i] <= 32'hFFFF_FFFF;
            end else begin
                if (ent_wr && (ent_sel == 2'(i))) begin
                    case (reg_addr[3:2])
                        `FPC_ENT_CFG: cfg_reg[i] <= fpc_cfg_t'(reg_wdata[27:0]);
                        `FPC_ENT_VAL: val_reg[i] <= reg_wdata;
                        `FPC_ENT_MIN: min_reg[i] <= reg_wdata;
                        default:      max_reg[i] <= reg_wdata;
                    endcase
                end
                if (wr_ok && (sel == 2'(i))) begin
                    val_reg[i] <= dif.val;
                end
            end
        end
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_addr == `FPC_CTRL_ADDR) begin
            reg_rdata <= ctrl_reg;
        end else if (reg_addr == `FPC_STATUS_ADDR) begin
            reg_rdata <= {resp_cnt_reg, 7'h00, last_err_reg, last_code_reg};
        end else if (reg_addr == `FPC_FORCE_ADDR) begin
            reg_rdata <= {23'h00_0000, force_reg};
        end else if ((reg_addr[7:4] >= `FPC_ENT_BASE)
                     && (reg_addr[7:4] < 4'(`FPC_ENT_BASE + NE))) begin
            case (reg_addr[3:2])
                `FPC_ENT_CFG: reg_rdata <= {4'h0, cfg_reg[ent_sel]};
                `FPC_ENT_VAL: reg_rdata <= val_reg[ent_sel];
                `FPC_ENT_MIN: reg_rdata <= min_reg[ent_sel];
                default:      reg_rdata <= max_reg[ent_sel];
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Checks on the response path
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_one_response: assert property (req_valid |=> resp_valid)
        else $error("request without response");
    a_no_spurious: assert property (!req_valid |=> !resp_valid)
        else $error("response without request");
    a_echo_number: assert property (req_valid |=> resp_w1[10:0] == $past(req_w1[10:0]))
        else $error("number not echoed");
    a_echo_index: assert property (req_valid |=> resp_w2 == $past(req_w2))
        else $error("index word not echoed");
    a_rsvd_zero: assert property (resp_valid |-> !resp_w1[11])
        else $error("reserved bit set");
    a_unsup_code: assert property (req_valid && dif.unsup |=>
        resp_w1[15:12] == `FPC_RID_ERR && resp_w4 == `FPC_E_UNSUP)
        else $error("unsupported id not refused");
    a_bad_page: assert property (req_valid && !dif.num_ok && dif.rid == 4'h1 |=>
        resp_w1[15:12] == `FPC_RID_ERR && resp_w4 == `FPC_E_NONUM)
        else $error("bad page accepted");
    a_err_high: assert property (resp_valid && resp_w1[15:12] == `FPC_RID_ERR
        |-> resp_w3 == 16'h0000)
        else $error("error response high word");
    a_word_high: assert property (resp_valid && resp_w1[15:12] == 4'h1
        |-> resp_w3 == 16'h0000)
        else $error("word value high word not zero");
    a_master_ctl: assert property (req_valid && dif.change && !ctrl_reg[`FPC_CTRL_MASTER]
        |=> resp_w1[15:12] == `FPC_RID_ERR)
        else $error("change accepted without master control");
    // Answer content checks
    a_idle_id: assert property (req_valid && dif.rid == 4'h0 |=>
        resp_w1[15:12] == 4'h0)
        else $error("no-request answered with an identifier");
    a_err_code: assert property (resp_valid && resp_w1[15:12] == `FPC_RID_ERR
        |-> resp_w4[15:8] == 8'h00)
        else $error("error code out of range");
    a_ro_refused: assert property (req_valid && dif.change && found && cfg.ro
        |=> resp_w1[15:12] == `FPC_RID_ERR)
        else $error("read-only entry changed");
    a_write_echo: assert property (wr_ok |=> resp_w1[15:12] != `FPC_RID_ERR
        && resp_w4 == $past(dif.val[15:0]))
        else $error("written value not echoed");

    c_read_ok: cover property (req_valid && dif.rid == 4'h6 && !err);
    c_forced: cover property (req_valid && force_use);
    c_write_ok: cover property (wr_ok ##1 resp_valid);
    c_limit_err: cover property (req_valid && err && code == `FPC_E_LIMIT);
endmodule : fpc_channel
`default_nettype wire

// >>> fpc_master_model.sv
// Behavioural fieldbus master that sends request telegrams to the channel
`timescale 1ns/1ps
`default_nettype none
module fpc_master_model
    import fpc_pkg::*;
(
    // Clock
    input  wire logic      clk_sys,
    // Request telegram
    output logic           req_valid,
    output fpc_word_t      req_w1,
    output fpc_word_t      req_w2,
    output fpc_word_t      req_w3,
    output fpc_word_t      req_w4,
    // Response telegram
    input  wire logic      resp_valid,
    input  wire fpc_word_t resp_w1,
    input  wire fpc_word_t resp_w2
);
    // Quiet bus at time zero
    initial begin
        req_valid = 1'b0;
        {req_w1, req_w2, req_w3, req_w4} = 64'h0;
    end

    // Send one whole telegram, up to three times in all, until the answer matches it
    task automatic send(input fpc_rid_t id, input logic [10:0] base,
                        input logic [7:0] sub, input logic [7:0] page,
                        input logic [31:0] v);
        logic ok;
        ok = 1'b0;
        for (int k = 0; k < 3 && !ok; k++) begin
            @(posedge clk_sys);
            req_valid <= 1'b1;
            req_w1    <= {id, 1'b0, base};
            req_w2    <= {sub, page};
            req_w3    <= v[31:16];
            req_w4    <= v[15:0];
            @(posedge clk_sys);
            req_valid <= 1'b0;
            // Released words flip so a stale value is never mistaken for data
            {req_w1, req_w2, req_w3, req_w4} <= ~{req_w1, req_w2, req_w3, req_w4};
            #1;
            ok = (resp_valid === 1'b1) && (resp_w1[10:0] === base)
                 && (resp_w2 === {sub, page});
        end
    endtask : send
endmodule : fpc_master_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the parameter channel
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fpc_pkg::*;
    logic        clk_sys   = 1'b0;  // 10 MHz system clock
    logic        rst       = 1'b1;  // Synchronous reset
    logic        req_valid;         // From the master model
    fpc_word_t   req_w1, req_w2, req_w3, req_w4;
    logic        resp_valid;        // From the channel
    fpc_word_t   resp_w1, resp_w2, resp_w3, resp_w4;
    logic [7:0]  reg_addr  = 8'h00; // Register port, idle at start
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    int          n_fail    = 0;     // Mismatches
    int          compares  = 0;     // Comparisons made
    int          cycles    = 0;     // Hang guard
    // Forced codes and control settings with the codes they provoke
    localparam fpc_word_t FC [7] = '{16'h6, 16'h7, 16'hC, 16'h14, 16'h68, 16'hC8, 16'hC9};
    localparam logic [31:0] CV [4] = '{32'h8, 32'h1, 32'hB, 32'hD};
    localparam fpc_word_t CE [4] = '{16'hB, 16'hCC, 16'h6B, 16'h11};

    always #50 clk_sys = ~clk_sys;

    fpc_channel uut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
        .req_w1(req_w1), .req_w2(req_w2), .req_w3(req_w3), .req_w4(req_w4),
        .resp_valid(resp_valid), .resp_w1(resp_w1), .resp_w2(resp_w2),
        .resp_w3(resp_w3), .resp_w4(resp_w4), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    fpc_master_model mst (.clk_sys(clk_sys), .req_valid(req_valid), .req_w1(req_w1),
        .req_w2(req_w2), .req_w3(req_w3), .req_w4(req_w4), .resp_valid(resp_valid),
        .resp_w1(resp_w1), .resp_w2(resp_w2));

    // Verdict and end of run
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    // Compare one value against its expectation
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle register read, data checked in the following cycle only
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd

    // Telegram exchange with the expected response words
    task automatic tel(input fpc_rid_t id, input logic [10:0] b, input logic [7:0] s,
                       input logic [7:0] p, input logic [31:0] v, input fpc_rid_t er,
                       input fpc_word_t e3, input fpc_word_t e4);
        mst.send(id, b, s, p, v);
        chk({31'h0, resp_valid}, 32'h1);
        chk(resp_w1, {er, 1'b0, b});
        chk(resp_w2, {s, p});
        chk({resp_w3, resp_w4}, {e3, e4});
    endtask : tel

    // Hang guard, far above the 110 or so cycles the tests need
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h00, 32'h9);
        rd(8'h0C, 32'h0);
        // Entries: indexed 7841, dword 2500, read-only 8005, word 20001
        wr(8'h10, 32'h0044_1EA1); wr(8'h14, 32'h1234); wr(8'h1C, 32'h100);
        wr(8'h20, 32'h0002_09C4); wr(8'h30, 32'h0001_1F45); wr(8'h40, 32'h4E21);
        $display("test setup done");
        tel(4'h6, 11'h731, 8'h02, 8'h90, 32'h0, 4'h4, 16'h0, 16'h1234);
        tel(4'h0, 11'h731, 8'h00, 8'h90, 32'h0, 4'h0, 16'h0, 16'h0);
        tel(4'h6, 11'h731, 8'h04, 8'h90, 32'h0, 4'h7, 16'h0, 16'h3);
        tel(4'h6, 11'h731, 8'h01, 8'h10, 32'h0, 4'h7, 16'h0, 16'h0);
        tel(4'h1, 11'h001, 8'h00, 8'h50, 32'h0, 4'h1, 16'h0, 16'h0);
        tel(4'h1, 11'h000, 8'h00, 8'h00, 32'h0, 4'h7, 16'h0, 16'h0);
        tel(4'h6, 11'h1F4, 8'h01, 8'h80, 32'h0, 4'h7, 16'h0, 16'h4);
        tel(4'h4, 11'h731, 8'h00, 8'h90, 32'h0, 4'h7, 16'h0, 16'h66);
        for (int i = 5; i < 16; i += 5)
            tel(fpc_rid_t'(i), 11'h731, 8'h00, 8'h90, 32'h0, 4'h7, 16'h0, 16'h6A);
        $display("test reads done");
        tel(4'h3, 11'h1F4, 8'h00, 8'h80, 32'hABCD_0001, 4'h2, 16'hABCD, 16'h1);
        tel(4'h7, 11'h731, 8'h01, 8'h90, 32'h200, 4'h7, 16'h0, 16'h2);
        tel(4'h7, 11'h731, 8'h01, 8'h90, 32'h55, 4'h4, 16'h0, 16'h55);
        tel(4'h8, 11'h731, 8'h01, 8'h90, 32'h55, 4'h7, 16'h0, 16'h5);
        tel(4'h2, 11'h005, 8'h00, 8'h20, 32'h1, 4'h7, 16'h0, 16'h1);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, CV[i]);
            tel(4'h7, 11'h731, 8'h01, 8'h90, 32'h55, 4'h7, 16'h0, CE[i]);
        end
        wr(8'h00, 32'h9);
        $display("test control done");
        for (int i = 0; i < 7; i++) begin
            wr(8'h08, {24'h1, FC[i][7:0]});
            tel(4'h7, 11'h731, 8'h01, 8'h90, 32'h56, 4'h7, 16'h0, FC[i]);
        end
        // Arm clears after one use, so the next change succeeds
        tel(4'h7, 11'h731, 8'h01, 8'h90, 32'h56, 4'h4, 16'h0, 16'h56);
        wr(8'h40, 32'h0008_4E21);
        tel(4'h1, 11'h001, 8'h00, 8'h50, 32'h0, 4'h7, 16'h0, 16'h65);
        rd(8'h14, 32'h56);
        rd(8'h40, 32'h0008_4E21);
        rd(8'h04, 32'h001D_0165);
        $display("test codes done");
        close_out();
    end
endmodule : tb
`default_nettype wire
